//--- logic/fswe_ctrl.sv
// Status register and write enable command logic of a serial flash, link side and system side
`timescale 1ns/10ps
module fswe_ctrl #(
    parameter int                 TW_NS      = 5000000,
    parameter fswe_pkg::fswe_status_t NV_DEFAULT = fswe_pkg::STATUS_DEFAULT
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_spi_clk,
    input  wire logic                  i_spi_cs_n,
    input  wire logic [3:0]            i_io,
    output logic      [3:0]            o_io,
    output logic      [3:0]            o_io_oe_n,
    input  wire logic                  i_four_wire_command_mode,
    input  wire logic                  i_hw_reset_n,
    input  wire logic                  i_array_done,
    input  wire logic [7:0]            i_rd_data,
    output logic                       o_array_start,
    output logic      [7:0]            o_array_opcode,
    output fswe_pkg::fswe_status_t     o_status,
    output logic                       o_busy,
    output logic                       o_write_enable_latch,
    output logic      [2:0]            o_wrap_bits
);
    import fswe_pkg::*;

    localparam int TW_CYC = (TW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W  = $clog2(TW_CYC + 1);

    generate
        if (TW_CYC < TSHSL2_CYC || TW_CYC < 1) begin : g_bad_tw
            $error("TW_NS too small for the write cycle timer");
        end
    endgenerate

    function automatic logic is_quad_io(input logic [7:0] op);
        is_quad_io = (op == OP_QIO_READ) || (op == OP_WORD_READ);
    endfunction

    function automatic logic needs_wel(input logic [7:0] op);
        case (op)
            OP_PP, OP_QPP, OP_SE, OP_BE32, OP_BE64,
            OP_CE, OP_CE_ALT, OP_SEC_ERASE, OP_SEC_PROG: needs_wel = 1'b1;
            default: needs_wel = 1'b0;
        endcase
    endfunction

    // Keep writable bits from data, OTP bits may only rise, frozen bits keep old value
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] data,
                                              input logic [7:0] wmask, input logic [7:0] otp,
                                              input logic [7:0] keep);
        logic [7:0] r;
        r = (old & ~wmask) | (data & wmask);
        r = r | (old & otp);
        merge_byte = (r & ~keep) | (old & keep);
    endfunction

    // ------------------------------------------------------------------ link domain
    logic         in_frame;
    logic [6:0]   clk_cnt;
    logic [6:0]   bit_cnt;
    logic [23:0]  shift_in;
    logic [7:0]   lk_op;
    logic         lk_qpi_s1;
    logic         lk_qpi;
    fswe_status_t lk_stat_s1;
    fswe_status_t lk_stat;
    logic [6:0]   cur_bits;
    logic [6:0]   op_clks;
    logic [6:0]   rel_clk;
    logic         quad_now;
    logic [6:0]   next_bits;
    logic [23:0]  next_shift;

    // Frame start flag: cleared by chip select high so the first edge restarts counting
    always_ff @(posedge i_spi_clk or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge i_spi_clk or posedge i_rst) begin
        if (i_rst) begin
            lk_qpi_s1  <= 1'b0;
            lk_qpi     <= 1'b0;
            lk_stat_s1 <= STATUS_DEFAULT;
            lk_stat    <= STATUS_DEFAULT;
        end else begin
            lk_qpi_s1  <= i_four_wire_command_mode;
            lk_qpi     <= lk_qpi_s1;
            lk_stat_s1 <= o_status;
            lk_stat    <= lk_stat_s1;
        end
    end

    always_comb begin
        cur_bits = in_frame ? bit_cnt : 7'd0;
        op_clks  = lk_qpi ? OP_CLK_QUAD : OP_CLK_SPI;
        rel_clk  = clk_cnt - op_clks;
        quad_now = lk_qpi || (in_frame && cur_bits >= BITS_OP && is_quad_io(lk_op));
        if (quad_now) begin
            next_shift = {shift_in[19:0], i_io[3], i_io[2], i_io[1], i_io[0]};
            next_bits  = (cur_bits > CNT_MAX - QUAD_STEP) ? CNT_MAX : cur_bits + QUAD_STEP;
        end else begin
            next_shift = {shift_in[22:0], i_io[0]};
            next_bits  = (cur_bits == CNT_MAX) ? CNT_MAX : cur_bits + SPI_STEP;
        end
    end

    // Shift and counts hold after chip select rises so the system side can read them
    always_ff @(posedge i_spi_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_in <= 24'h000000;
            bit_cnt  <= 7'd0;
            clk_cnt  <= 7'd0;
        end else begin
            shift_in <= next_shift;
            bit_cnt  <= next_bits;
            clk_cnt  <= in_frame ? ((clk_cnt == CNT_MAX) ? CNT_MAX : clk_cnt + 7'd1) : 7'd1;
        end
    end

    always_ff @(posedge i_spi_clk or posedge i_rst) begin
        if (i_rst) begin
            lk_op <= 8'h00;
        end else if (next_bits == BITS_OP) begin
            lk_op <= next_shift[7:0];
        end
    end

    always_ff @(posedge i_spi_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wrap_bits <= 3'b000;
        end else if (in_frame && lk_op == OP_WRAP && cur_bits >= BITS_OP && rel_clk == WRAP_REL) begin
            o_wrap_bits <= i_io[2:0];
        end
    end

    logic [7:0] out_byte;
    logic       rd_stat;
    logic [6:0] data_rel;
    logic       data_go;

    always_comb begin
        rd_stat  = (lk_op == OP_RDSR1) || (lk_op == OP_RDSR2) || (lk_op == OP_RDSR3);
        case (lk_op)
            OP_RDSR2: out_byte = lk_stat.sr2;
            OP_RDSR3: out_byte = lk_stat.sr3;
            OP_RDSR1: out_byte = lk_stat.sr1;
            default:  out_byte = i_rd_data;
        endcase
        data_rel = (lk_op == OP_WORD_READ) ? WORD_DATA_REL : QIO_DATA_REL;
        data_go  = is_quad_io(lk_op) && bit_cnt >= BITS_OP && rel_clk >= data_rel;
    end

    // Output changes on the falling edge so the host samples it on the next rising edge
    always_ff @(negedge i_spi_clk or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            o_io      <= 4'h0;
            o_io_oe_n <= 4'hF;
        end else if (rd_stat && bit_cnt >= BITS_OP) begin
            if (lk_qpi) begin
                o_io      <= bit_cnt[2] ? out_byte[3:0] : out_byte[7:4];
                o_io_oe_n <= 4'h0;
            end else begin
                o_io      <= {2'b00, out_byte[3'd7 - bit_cnt[2:0]], 1'b0};
                o_io_oe_n <= 4'hD;
            end
        end else if (data_go) begin
            o_io      <= (rel_clk[0] ^ data_rel[0]) ? out_byte[3:0] : out_byte[7:4];
            o_io_oe_n <= 4'h0;
        end else begin
            o_io      <= 4'h0;
            o_io_oe_n <= 4'hF;
        end
    end

    // ------------------------------------------------------------------ system domain
    typedef enum logic [1:0] {ST_IDLE, ST_NV_WRITE, ST_VOL_WRITE, ST_ARRAY} fswe_state_t;

    fswe_state_t  state;
    logic [TMR_W-1:0] timer;
    logic         cs_s1;
    logic         cs_s2;
    logic         cs_s3;
    logic         hr_s1;
    logic         hr_s2;
    logic         qm_s1;
    logic         qm_s2;
    logic         write_enable_latch;
    logic         vol_armed;
    logic         rst_armed;
    fswe_status_t nv;
    fswe_status_t vol;
    fswe_status_t pend;
    fswe_frame_t  fr;
    fswe_status_t base;
    fswe_status_t next_pend;
    logic         frame_end;
    logic         idle;
    logic         wr_op;
    logic         len_ok;
    logic         ev_wren;
    logic         ev_wrdi;
    logic         ev_nv;
    logic         ev_vol;
    logic         ev_array;
    logic         ev_reset;
    logic         done;
    logic [7:0]   otp2;
    logic [7:0]   keep2;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            hr_s1 <= 1'b1;
            hr_s2 <= 1'b1;
            qm_s1 <= 1'b0;
            qm_s2 <= 1'b0;
        end else begin
            cs_s1 <= i_spi_cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            hr_s1 <= i_hw_reset_n;
            hr_s2 <= hr_s1;
            // Mode pin is asynchronous to this clock
            qm_s1 <= i_four_wire_command_mode;
            qm_s2 <= qm_s1;
        end
    end

    // Frame words are stable once chip select is high, since the link clock has stopped
    always_comb begin
        fr.bits = bit_cnt;
        fr.op   = 8'h00;
        fr.d0   = 8'h00;
        fr.d1   = 8'h00;
        if (bit_cnt == BITS_OP) begin
            fr.op = shift_in[7:0];
        end else if (bit_cnt == BITS_ONE) begin
            fr.op = shift_in[15:8];
            fr.d0 = shift_in[7:0];
        end else if (bit_cnt == BITS_TWO) begin
            fr.op = shift_in[23:16];
            fr.d0 = shift_in[15:8];
            fr.d1 = shift_in[7:0];
        end
    end

    always_comb begin
        frame_end = cs_s2 && !cs_s3;
        idle      = (state == ST_IDLE);
        done      = (state == ST_NV_WRITE || state == ST_VOL_WRITE) && timer == '0;
        wr_op     = (fr.op == OP_WRSR1) || (fr.op == OP_WRSR2) || (fr.op == OP_WRSR3);
        len_ok    = (fr.bits == BITS_ONE) || (fr.op == OP_WRSR1 && fr.bits == BITS_TWO);
        ev_wren   = frame_end && idle && fr.bits == BITS_OP && fr.op == OP_WREN;
        ev_wrdi   = frame_end && idle && fr.bits == BITS_OP && fr.op == OP_WRDI;
        ev_vol    = frame_end && idle && wr_op && len_ok && vol_armed;
        ev_nv     = frame_end && idle && wr_op && len_ok && !vol_armed && write_enable_latch;
        ev_array  = frame_end && idle && fr.bits >= BITS_OP && needs_wel(fr.op) && write_enable_latch;
        ev_reset  = !hr_s2 || (frame_end && rst_armed && fr.bits == BITS_OP
                               && fr.op == OP_RST_DEV);
        // Volatile path also protects the second protect bit from falling
        otp2      = vol_armed ? (SR2_LOCK | SR2_PROT2) : SR2_LOCK;
        keep2     = qm_s2 ? SR2_QE : NO_BITS;
        base      = vol_armed ? vol : nv;
        next_pend = base;
        case (fr.op)
            OP_WRSR1: begin
                next_pend.sr1 = merge_byte(base.sr1, fr.d0, SR1_WMASK, NO_BITS, NO_BITS);
                if (fr.bits == BITS_TWO) begin
                    next_pend.sr2 = merge_byte(base.sr2, fr.d1, SR2_WMASK, otp2, keep2);
                end
            end
            OP_WRSR2: next_pend.sr2 = merge_byte(base.sr2, fr.d0, SR2_WMASK, otp2, keep2);
            OP_WRSR3: next_pend.sr3 = merge_byte(base.sr3, fr.d0, SR3_WMASK, NO_BITS, NO_BITS);
            default:  next_pend = base;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            timer <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ev_nv) begin
                        state <= ST_NV_WRITE;
                        timer <= TMR_W'(TW_CYC - 1);
                    end else if (ev_vol) begin
                        state <= ST_VOL_WRITE;
                        timer <= TMR_W'(TSHSL2_CYC - 1);
                    end else if (ev_array) begin
                        state <= ST_ARRAY;
                    end
                end
                ST_NV_WRITE, ST_VOL_WRITE: begin
                    if (timer == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - TMR_W'(1);
                    end
                end
                ST_ARRAY: begin
                    if (i_array_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pend <= STATUS_DEFAULT;
        end else if (ev_nv || ev_vol) begin
            pend <= next_pend;
        end
    end

    // Non-volatile copy survives resets other than power-up
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            nv <= NV_DEFAULT;
        end else if (done && state == ST_NV_WRITE) begin
            nv <= pend;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            vol <= NV_DEFAULT;
        end else if (ev_reset) begin
            vol <= nv;
        end else if (done) begin
            vol <= pend;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            write_enable_latch <= 1'b0;
        end else if (ev_reset) begin
            write_enable_latch <= 1'b0;
        end else if (ev_wren) begin
            write_enable_latch <= 1'b1;
        end else if (ev_wrdi) begin
            write_enable_latch <= 1'b0;
        end else if ((done && state == ST_NV_WRITE) || (state == ST_ARRAY && i_array_done)) begin
            write_enable_latch <= 1'b0;
        end
    end

    // Arming lasts until the next completed command frame or a reset, whichever comes first
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            vol_armed <= 1'b0;
        end else if (ev_reset) begin
            vol_armed <= 1'b0;
        end else if (frame_end && idle && fr.bits >= BITS_OP) begin
            vol_armed <= (fr.op == OP_VWREN) && (fr.bits == BITS_OP);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_armed <= 1'b0;
        end else if (frame_end && fr.bits >= BITS_OP) begin
            rst_armed <= (fr.op == OP_RST_EN) && (fr.bits == BITS_OP);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_array_start  <= 1'b0;
            o_array_opcode <= 8'h00;
        end else begin
            o_array_start <= ev_array;
            if (ev_array) begin
                o_array_opcode <= fr.op;
            end
        end
    end

    // Busy covers non-volatile and array cycles only; volatile refresh keeps it low
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status             <= STATUS_DEFAULT;
            o_busy               <= 1'b0;
            o_write_enable_latch <= 1'b0;
        end else begin
            o_status                   <= vol;
            o_status.sr1[SR1_BUSY_BIT] <= (state == ST_NV_WRITE) || (state == ST_ARRAY);
            o_status.sr1[SR1_WEL_BIT]  <= write_enable_latch;
            o_busy                     <= (state == ST_NV_WRITE) || (state == ST_ARRAY);
            o_write_enable_latch       <= write_enable_latch;
        end
    end
endmodule

//--- logic/fswe_pkg.sv
// Shared opcodes, status layouts, timing and carrier types for the status/write-enable block
package fswe_pkg;
    // Opcodes handled by this block
    localparam logic [7:0] OP_WREN      = 8'h06;
    localparam logic [7:0] OP_VWREN     = 8'h50;
    localparam logic [7:0] OP_WRDI      = 8'h04;
    localparam logic [7:0] OP_RDSR1     = 8'h05;
    localparam logic [7:0] OP_RDSR2     = 8'h35;
    localparam logic [7:0] OP_RDSR3     = 8'h15;
    localparam logic [7:0] OP_WRSR1     = 8'h01;
    localparam logic [7:0] OP_WRSR2     = 8'h31;
    localparam logic [7:0] OP_WRSR3     = 8'h11;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST_DEV   = 8'h99;
    localparam logic [7:0] OP_QIO_READ  = 8'hEB;
    localparam logic [7:0] OP_WORD_READ = 8'hE7;
    localparam logic [7:0] OP_WRAP      = 8'h77;
    // Opcodes that need the write enable latch
    localparam logic [7:0] OP_PP        = 8'h02;
    localparam logic [7:0] OP_QPP       = 8'h32;
    localparam logic [7:0] OP_SE        = 8'h20;
    localparam logic [7:0] OP_BE32      = 8'h52;
    localparam logic [7:0] OP_BE64      = 8'hD8;
    localparam logic [7:0] OP_CE        = 8'hC7;
    localparam logic [7:0] OP_CE_ALT    = 8'h60;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG  = 8'h42;

    // Status register 1 bit positions and writable mask
    localparam int         SR1_BUSY_BIT = 0;
    localparam int         SR1_WEL_BIT  = 1;
    localparam logic [7:0] SR1_WMASK    = 8'hBC;
    // Status register 2: protect-second b0, quad enable b1, lock b5:3, complement b6
    localparam logic [7:0] SR2_WMASK    = 8'h7B;
    localparam logic [7:0] SR2_PROT2    = 8'h01;
    localparam logic [7:0] SR2_QE       = 8'h02;
    localparam logic [7:0] SR2_LOCK     = 8'h38;
    // Status register 3: address default b1, dummy b3:2, drive b6:5, hold/reset b7
    localparam logic [7:0] SR3_WMASK    = 8'hEE;
    localparam logic [7:0] NO_BITS      = 8'h00;

    // Frame bit counts
    localparam logic [6:0] BITS_OP      = 7'd8;
    localparam logic [6:0] BITS_ONE     = 7'd16;
    localparam logic [6:0] BITS_TWO     = 7'd24;
    localparam logic [6:0] CNT_MAX      = 7'h7F;
    localparam logic [6:0] SPI_STEP     = 7'd1;
    localparam logic [6:0] QUAD_STEP    = 7'd4;
    // Opcode length in clocks
    localparam logic [6:0] OP_CLK_SPI   = 7'd8;
    localparam logic [6:0] OP_CLK_QUAD  = 7'd2;
    // Clock offsets counted from the end of the opcode
    localparam logic [6:0] QIO_DATA_REL  = 7'd14;
    localparam logic [6:0] WORD_DATA_REL = 7'd12;
    localparam logic [6:0] WRAP_REL      = 7'd6;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TSHSL2_NS     = 50;
    localparam int TSHSL2_CYC    = (TSHSL2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] sr3;
        logic [7:0] sr2;
        logic [7:0] sr1;
    } fswe_status_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [6:0] bits;
    } fswe_frame_t;

    localparam logic [23:0] STATUS_DEFAULT = 24'h000000;
endpackage

//--- verification/fswe_ctrl_properties.sv
// Concurrent checks on the status and write enable block ports
`timescale 1ns/10ps
module fswe_ctrl_properties
    import fswe_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_spi_cs_n,
    input  wire logic [3:0]             o_io_oe_n,
    input  wire logic                   o_array_start,
    input  wire fswe_pkg::fswe_status_t o_status,
    input  wire logic                   o_busy,
    input  wire logic                   o_write_enable_latch
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    busy_bit_a: assert property (
        o_status.sr1[SR1_BUSY_BIT] == o_busy) else $error("busy bit wrong");
    latch_bit_a: assert property (
        o_status.sr1[SR1_WEL_BIT] == o_write_enable_latch) else $error("latch bit wrong");
    lock_kept_a: assert property (
        (($past(o_status.sr2) & ~o_status.sr2) & SR2_LOCK) == NO_BITS) else $error("lock cleared");
    read_only_a: assert property (
        ((o_status.sr1 & ~(SR1_WMASK | 8'h03)) | (o_status.sr2 & ~SR2_WMASK)
         | (o_status.sr3 & ~SR3_WMASK)) == NO_BITS) else $error("read-only bit set");
    oe_idle_a: assert property (
        i_spi_cs_n && $past(i_spi_cs_n) |-> o_io_oe_n == 4'hF) else $error("pins driven idle");
    start_pulse_a: assert property (
        o_array_start |=> !o_array_start) else $error("start pulse too long");
    start_busy_a: assert property (
        o_array_start |-> ##[0:2] o_busy) else $error("array op without busy");
    busy_end_a: assert property (
        $fell(o_busy) |-> !o_write_enable_latch) else $error("latch left after cycle");
endmodule

bind fswe_ctrl fswe_ctrl_properties i_fswe_ctrl_properties (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n), .o_io_oe_n(o_io_oe_n),
    .o_array_start(o_array_start), .o_status(o_status), .o_busy(o_busy),
    .o_write_enable_latch(o_write_enable_latch));

//--- verification/fswe_host.sv
// Host flash controller model driving the serial link
`timescale 1ns/10ps
module fswe_host (
    output logic            o_sclk,
    output logic            o_cs_n,
    output logic [3:0]      o_io,
    input  wire logic [3:0] i_io,
    input  wire logic       i_quad
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'h0;
    end
    // Clock stands low between frames; bits change only while it is low
    task automatic xfer(input logic [23:0] d, input int nb, input int nr,
                        output logic [15:0] rd);
        int st;
        st = i_quad ? 4 : 1;
        rd = 16'h0000;
        o_cs_n = 1'b0;
        #4;
        for (int i = nb - st; i >= 0; i -= st) begin
            o_io = i_quad ? d[i+:4] : {~o_io[3:1], d[i]};
            #3 o_sclk = 1'b1;
            #3 o_sclk = 1'b0;
        end
        for (int j = 0; j < nr; j++) begin
            #3 o_sclk = 1'b1;
            rd = {rd[14:0], i_io[1]};
            #3 o_sclk = 1'b0;
        end
        #3 o_cs_n = 1'b1;
        // Released lines flip so a stale level cannot pass for data
        o_io = ~o_io;
        #60;
    endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the status and write enable block
`timescale 1ns/10ps
module testbench;
    import fswe_pkg::*;
    logic         clk, rst, quad, hwr_n, done, sclk, cs_n, start, busy, write_enable_latch;
    logic         seen = 1'b0;
    logic [7:0]   aop;
    logic [15:0]  rd;
    logic [3:0]   sio, dio, doe_n, pin;
    fswe_status_t st;
    int           fail_count = 0;
    int           num_checks = 0;
    assign pin = (~doe_n & dio) | (doe_n & sio);
    always @(posedge clk) seen <= seen | start;
    fswe_ctrl #(.TW_NS(400)) i_fswe_ctrl (.i_sys_clk(clk), .i_rst(rst), .i_spi_clk(sclk),
        .i_spi_cs_n(cs_n), .i_io(pin), .o_io(dio), .o_io_oe_n(doe_n),
        .i_four_wire_command_mode(quad), .i_hw_reset_n(hwr_n), .i_array_done(done),
        .i_rd_data(8'h5A), .o_array_start(start), .o_array_opcode(aop), .o_status(st),
        .o_busy(busy), .o_write_enable_latch(write_enable_latch), .o_wrap_bits());
    fswe_host i_fswe_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(sio), .i_io(pin), .i_quad(quad));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        @(negedge clk);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic cmd(input logic [23:0] d, input int nb);
        i_fswe_host.xfer(d, nb, 0, rd);
        repeat (4) @(posedge clk);
        // Callers sample outputs right after, so leave the launching edge behind
        @(negedge clk);
    endtask
    task automatic rdsr(input logic [7:0] op, input logic [7:0] e);
        i_fswe_host.xfer({16'h0000, op}, 8, 16, rd);
        chk("status read", {8'h00, e, e}, {8'h00, rd});
    endtask
    task automatic idle;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // Status is polled mid-cycle, so the timed write must outlast one read frame
    task automatic nvw(input logic [23:0] d, input int nb);
        cmd(OP_WREN, 8);
        i_fswe_host.xfer(d, nb, 0, rd);
        chk("busy", 1'h1, busy);
        i_fswe_host.xfer({16'h0000, OP_RDSR1}, 8, 8, rd);
        chk("busy read", 2'h3, rd[1:0]);
        idle;
        chk("latch after", 1'h0, write_enable_latch);
    endtask
    initial begin
        rst = 1'b1;
        quad = 1'b0;
        hwr_n = 1'b1;
        done = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rdsr(OP_RDSR1, 8'h00);
        cmd(OP_WREN, 8);
        chk("latch set", 1'h1, write_enable_latch);
        rdsr(OP_RDSR1, 8'h02);
        cmd(OP_WRDI, 8);
        chk("latch clear", 1'h0, write_enable_latch);
        cmd({OP_WRSR1, 8'hFC}, 16);
        chk("unarmed write", 24'h000000, st);
        nvw({OP_WRSR1, 8'hFF}, 16);
        chk("sr1", 24'h0000BC, st);
        nvw({OP_WRSR1, 8'hA5, 8'hFF}, 24);
        chk("sr1 sr2", 24'h007BA4, st);
        nvw({OP_WRSR1, 8'h00}, 16);
        chk("sr1 only", 24'h007B00, st);
        nvw({OP_WRSR2, 8'h00}, 16);
        chk("locks kept", 24'h003800, st);
        cmd(OP_VWREN, 8);
        chk("vol latch", 1'h0, write_enable_latch);
        i_fswe_host.xfer({OP_WRSR2, 8'h01}, 16, 0, rd);
        chk("vol busy", 1'h0, busy);
        repeat (6) @(negedge clk);
        chk("vol sr2", 24'h003900, st);
        cmd(OP_VWREN, 8);
        cmd({OP_WRSR2, 8'h00}, 16);
        repeat (6) @(negedge clk);
        chk("vol otp", 24'h003900, st);
        cmd(OP_VWREN, 8);
        cmd({OP_WRSR3, 8'hFF}, 16);
        repeat (6) @(posedge clk);
        rdsr(OP_RDSR3, 8'hEE);
        rdsr(OP_RDSR2, 8'h39);
        cmd(OP_RST_EN, 8);
        cmd(OP_RST_DEV, 8);
        repeat (6) @(negedge clk);
        chk("reload", 24'h003800, st);
        @(posedge clk) quad <= 1'b1;
        repeat (4) @(posedge clk);
        // Mode crosses on the link clock; a throwaway frame lets it settle
        cmd(NO_BITS, 8);
        cmd(OP_WREN, 8);
        i_fswe_host.xfer({OP_WRSR2, 8'h02}, 16, 0, rd);
        chk("quad busy", 1'h1, busy);
        idle;
        chk("qe frozen", 24'h003800, st);
        @(posedge clk) quad <= 1'b0;
        repeat (4) @(posedge clk);
        cmd(NO_BITS, 8);
        cmd(OP_CE, 8);
        chk("refused start", 1'h0, seen);
        cmd(OP_WREN, 8);
        cmd(OP_CE, 8);
        chk("start", {1'b1, OP_CE}, {seen, aop});
        chk("array busy", 1'h1, busy);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        idle;
        chk("array latch", 1'h0, write_enable_latch);
        cmd(OP_WREN, 8);
        @(posedge clk) hwr_n <= 1'b0;
        repeat (4) @(posedge clk);
        hwr_n <= 1'b1;
        repeat (4) @(negedge clk);
        chk("hw reset latch", 1'h0, write_enable_latch);
        report_and_stop;
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop;
    end
endmodule
